// file: hdl/adc_ctrl_params.svh
// Purpose: Named constants for the converter result/standby control block.
// Assumes: Included by the control module.
// Notes:   Times are in their own unit; cycle counts derive in the module.
`ifndef ADC_CTRL_PARAMS_SVH
`define ADC_CTRL_PARAMS_SVH

`define CLK_FREQ_HZ      250000000
`define SYS_FREQ_HZ      5000000
`define RATE_MILLIHZ     10170
`define HIGH_GAP_TICKS   500
`define SETTLE_PERIODS   3

`define CMD_WRITE_SETUP  8'hBF
`define CMD_READ_READY   8'h3F
`define CMD_READ_RESULT  8'h7F

`define CMD_BITS         5'd8
`define READY_BITS       5'd8
`define RESULT_BITS      5'd24

`define SETUP_RESET      8'h20
`define RESULT_RESET     24'h000000
`define CODE_POS_FULL    24'hD2F000
`define CODE_ZERO        24'h697800
`define CODE_NEG_FULL    24'h000000

`endif

// file: hdl/adc_ctrl_pkg.sv
// Purpose: Types shared by the converter control block and its bench.
// Assumes: Constants come from adc_ctrl_params.svh.
// Notes:   Setup layout is MSB first: zero, channel, gain, standby, zeros.
package adc_ctrl_pkg;

  typedef struct packed {
    logic       zeroTop;
    logic       channel;
    logic       gain;
    logic       power_down_bit;
    logic [3:0] zeroLow;
  } setup_t;

  typedef struct packed {
    logic sclk;
    logic serialDataIoIn;
  } link_in_t;

  typedef struct packed {
    logic serialDataIoOut;
    logic serialDataIoOe;
  } link_out_t;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_CMD   = 5'b00010,
    ST_WRITE = 5'b00100,
    ST_READ  = 5'b01000,
    ST_HOLD  = 5'b10000
  } link_state_t;

endpackage

// file: hdl/adc_result_ready_standby_ctrl.sv
// Purpose: Result pacing, ready flag, standby and two-wire link of a
//          single-channel sigma-delta converter.
// Assumes: clk 250 MHz; sclk and data pin are asynchronous to clk.
// Notes:   The 5 MHz system clock is a tick derived from clk.
// Contract
// - New result at 10.17 Hz, scales with clock
// - System clock internal, no external clock
// - Ready low when fresh word loaded
// - Ready high after full 24-bit read
// - Unread: ready high 500 ticks before update
// - Offset coding: D2F000, 697800, 000000
// - Standby stops new results
// - Standby holds tick count, settle count and result
// - Valid result three periods after standby cleared
// - Standby leaves link and ready alone
// - Ready level kept when standby cleared
// - Unread word readable in standby, ready rises
// - Setup bit: 0 normal, 1 standby
// - Read: command 7F, 24 bits MSB first
// - Command 3F: ready level over 8 clocks
`include "adc_ctrl_params.svh"
`timescale 1ns/1ns
`default_nettype none

module adc_result_ready_standby_ctrl #(
  parameter int unsigned UPDATE_TICKS =
    32'((64'(`SYS_FREQ_HZ) * 64'd1000) / 64'(`RATE_MILLIHZ))
) (
  // Clock and reset
  input  wire logic                 clk,
  input  wire logic                 nrst,
  // Two-wire link pins
  input  wire adc_ctrl_pkg::link_in_t   linkIn,
  output var  adc_ctrl_pkg::link_out_t  linkOut,
  // Ready pin, active low
  output var  logic                 resultReadyN,
  // Filter side
  input  wire logic signed [23:0]   sampleData,
  output var  adc_ctrl_pkg::setup_t setupOut
);
  import adc_ctrl_pkg::*;

  // Internal oscillator modelled as a tick every DIV clk cycles
  localparam int unsigned DIV = `CLK_FREQ_HZ / `SYS_FREQ_HZ;
  localparam int unsigned DW  = $clog2(DIV);
  localparam logic [DW-1:0] DIV_LAST = DW'(DIV - 1);
  localparam int unsigned TW  = $clog2(UPDATE_TICKS);
  localparam logic [TW-1:0] TICK_LAST = TW'(UPDATE_TICKS - 1);
  localparam logic [TW-1:0] GAP_POINT =
    TW'(UPDATE_TICKS - 1 - `HIGH_GAP_TICKS);
  localparam logic [1:0] SETTLE_SKIP = 2'(`SETTLE_PERIODS - 1);

  // Maps a signed filter word onto the offset output code
  function automatic logic [23:0] toOffset(input logic signed [23:0] d);
    logic signed [25:0] s;
    s = 26'(signed'({{2{d[23]}}, d}) + signed'({2'b00, `CODE_ZERO}));
    if (s < 26'sd0)
      return `CODE_NEG_FULL;
    if (s > signed'({2'b00, `CODE_POS_FULL}))
      return `CODE_POS_FULL;
    return s[23:0];
  endfunction

  // Only the written mode bits are kept; the fixed zeros stay zero
  function automatic setup_t toSetup(input logic [7:0] b);
    setup_t v;
    v = setup_t'(b);
    v.zeroTop = 1'b0;
    v.zeroLow = '0;
    return v;
  endfunction

  // Input synchronisers
  logic [1:0] sclkSync;
  logic [1:0] pinSync;
  logic       sclkPrev;
  logic       pinPrev;
  logic [1:0] next_sclkSync;
  logic [1:0] next_pinSync;
  logic       sclkS;
  logic       pinS;
  logic       sclkRise;
  logic       sclkFall;

  always_comb
  begin
    next_sclkSync = {sclkSync[0], linkIn.sclk};
    next_pinSync = {pinSync[0], linkIn.serialDataIoIn};
    sclkS = sclkSync[1];
    pinS = pinSync[1];
    sclkRise = sclkS & ~sclkPrev;
    sclkFall = ~sclkS & sclkPrev;
  end

  // Reset to idle-high levels so no false start is seen
  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      sclkSync <= 2'b11;
      pinSync <= 2'b11;
      sclkPrev <= 1'b1;
      pinPrev <= 1'b1;
    end
    else
    begin
      sclkSync <= next_sclkSync;
      pinSync <= next_pinSync;
      sclkPrev <= sclkS;
      pinPrev <= pinS;
    end
  end

  // Conversion pacing state
  logic [DW-1:0] divCount;
  logic [TW-1:0] tickCount;
  logic [1:0]    skipLeft;
  logic [23:0]   result;
  logic          readyN;
  logic          pdPrev;
  logic [DW-1:0] next_divCount;
  logic [TW-1:0] next_tickCount;
  logic [1:0]    next_skipLeft;
  logic [23:0]   next_result;
  logic          next_readyN;
  logic          next_pdPrev;
  logic          sysTick;
  logic          standby;
  logic          readDone;

  // Link state
  link_state_t state;
  link_state_t next_state;
  logic [4:0]  bitCount;
  logic [4:0]  next_bitCount;
  logic [7:0]  shiftIn;
  logic [7:0]  next_shiftIn;
  logic [23:0] shiftOut;
  logic [23:0] next_shiftOut;
  logic        dataRead;
  logic        next_dataRead;
  setup_t      setup;
  setup_t      next_setup;
  logic        outBit;
  logic        next_outBit;
  logic        outOe;
  logic        next_outOe;
  logic [7:0]  inByte;
  logic        startCond;
  logic        stopCond;

  assign standby = setup.power_down_bit;

  always_comb
  begin
    sysTick = (divCount == DIV_LAST);
    next_divCount = sysTick ? '0 : divCount + DW'(1);
    next_tickCount = tickCount;
    next_skipLeft = skipLeft;
    next_result = result;
    // A finished read releases ready, also during standby
    next_readyN = readDone ? 1'b1 : readyN;
    next_pdPrev = standby;
    // Standby freezes pacing only; link and ready run on
    if (!standby && pdPrev)
    begin
      // Filter must settle again; ready is left as it is
      next_tickCount = '0;
      next_skipLeft = SETTLE_SKIP;
    end
    else if (!standby && sysTick)
    begin
      if (tickCount == TICK_LAST)
      begin
        next_tickCount = '0;
        if (skipLeft != 2'd0)
          next_skipLeft = skipLeft - 2'd1;
        else
        begin
          // One-cycle load of the whole word
          next_result = toOffset(sampleData);
          next_readyN = 1'b0;
        end
      end
      else
      begin
        next_tickCount = tickCount + TW'(1);
        if (tickCount == GAP_POINT && skipLeft == 2'd0)
          next_readyN = 1'b1;
      end
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      divCount <= '0;
      tickCount <= '0;
      skipLeft <= SETTLE_SKIP;
      result <= `RESULT_RESET;
      readyN <= 1'b1;
      pdPrev <= 1'b0;
    end
    else
    begin
      divCount <= next_divCount;
      tickCount <= next_tickCount;
      skipLeft <= next_skipLeft;
      result <= next_result;
      readyN <= next_readyN;
      pdPrev <= next_pdPrev;
    end
  end

  // Start/stop only count while the host owns the data line
  always_comb
  begin
    inByte = {shiftIn[6:0], pinS};
    startCond = sclkS & sclkPrev & pinPrev & ~pinS & ~outOe;
    stopCond = sclkS & sclkPrev & ~pinPrev & pinS & ~outOe;
    next_state = state;
    next_bitCount = bitCount;
    next_shiftIn = shiftIn;
    next_shiftOut = shiftOut;
    next_dataRead = dataRead;
    next_setup = setup;
    next_outBit = outBit;
    next_outOe = outOe;
    readDone = 1'b0;
    if (stopCond)
      next_state = ST_IDLE;
    else if (startCond)
    begin
      next_state = ST_CMD;
      next_bitCount = '0;
    end
    else
    begin
      unique case (state)
        ST_IDLE: next_outOe = 1'b0;
        ST_CMD, ST_WRITE:
        begin
          if (sclkRise)
          begin
            next_shiftIn = inByte;
            next_bitCount = bitCount + 5'd1;
            if (bitCount == `CMD_BITS - 5'd1)
            begin
              next_bitCount = '0;
              next_state = ST_HOLD;
              if (state == ST_WRITE)
              begin
                next_setup = toSetup(inByte);
              end
              else if (inByte == `CMD_WRITE_SETUP)
              begin
                next_state = ST_WRITE;
              end
              else if (inByte == `CMD_READ_RESULT)
              begin
                // Snapshot so a late load cannot tear the word
                next_state = ST_READ;
                next_shiftOut = result;
                next_dataRead = 1'b1;
              end
              else if (inByte == `CMD_READ_READY)
              begin
                next_state = ST_READ;
                next_shiftOut = {{8{readyN}}, 16'h0000};
                next_dataRead = 1'b0;
              end
            end
          end
        end
        ST_READ:
        begin
          if (sclkFall)
          begin
            // MSB first, driven on the falling edge
            next_outOe = 1'b1;
            next_outBit = shiftOut[23];
            next_shiftOut = {shiftOut[22:0], 1'b0};
          end
          else if (sclkRise)
          begin
            next_bitCount = bitCount + 5'd1;
            if (bitCount == (dataRead ? `RESULT_BITS : `READY_BITS) - 5'd1)
            begin
              next_state = ST_HOLD;
              readDone = dataRead;
            end
          end
        end
        // Release the pin on the sclk fall after the last bit's high phase
        ST_HOLD: next_outOe = sclkFall ? 1'b0 : outOe;
      endcase
    end
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      state <= ST_IDLE;
      bitCount <= '0;
      shiftIn <= '0;
      shiftOut <= '0;
      dataRead <= 1'b0;
      setup <= setup_t'(`SETUP_RESET);
      outBit <= 1'b1;
      outOe <= 1'b0;
    end
    else
    begin
      state <= next_state;
      bitCount <= next_bitCount;
      shiftIn <= next_shiftIn;
      shiftOut <= next_shiftOut;
      dataRead <= next_dataRead;
      setup <= next_setup;
      outBit <= next_outBit;
      outOe <= next_outOe;
    end
  end

  // Host is trusted not to read while ready is high
  assign linkOut = '{serialDataIoOut: outBit, serialDataIoOe: outOe};
  assign resultReadyN = readyN;
  assign setupOut = setup;

endmodule

`default_nettype wire

// file: dv/adc_ctrl_assertions.sv
// Purpose: Port checks for the result/standby control block.
// Assumes: One clock domain; 50 clk per system tick.
// Notes:   Bound to the top module at the foot of this file.
`timescale 1ns/1ns
`default_nettype none
module adc_ctrl_assertions
  import adc_ctrl_pkg::*;
#(
  parameter int unsigned UPDATE_TICKS = 502
)
(
  // Clock and reset
  input wire logic                    clk,
  input wire logic                    nrst,
  // Block ports
  input wire adc_ctrl_pkg::link_in_t  linkIn,
  input wire adc_ctrl_pkg::link_out_t linkOut,
  input wire logic                    resultReadyN,
  input wire logic signed [23:0]      sampleData,
  input wire adc_ctrl_pkg::setup_t    setupOut
);
  localparam int unsigned START = 3 * UPDATE_TICKS * 50 - 100;
  localparam int unsigned LOWMAX = (UPDATE_TICKS - 500) * 50 + 4;
  logic [31:0] since, next_since, low, next_low;
  logic [4:0]  bits, next_bits, fall, next_fall;
  logic        sclkQ, next_sclkQ, pdSeen, next_pdSeen;

  always_comb
  begin
    next_since = (since == '1) ? since : since + 32'h1;
    if (setupOut.power_down_bit)
      next_since = '0;
    next_low = resultReadyN ? '0 : low + 32'h1;
    // Skipped periods keep ready low, so the gap check stops after standby
    next_pdSeen = pdSeen | setupOut.power_down_bit;
    next_sclkQ = linkIn.sclk;
    next_bits = bits;
    if (!linkOut.serialDataIoOe)
      next_bits = '0;
    else if (linkIn.sclk && !sclkQ)
      next_bits = bits + 5'h1;
    next_fall = (fall == '1) ? fall : fall + 5'h1;
    if (!linkIn.sclk && sclkQ)
      next_fall = '0;
  end

  always_ff @(posedge clk or negedge nrst)
  begin
    if (!nrst)
    begin
      since <= '0;
      low   <= '0;
      bits  <= '0;
      fall  <= '1;
      sclkQ <= 1'b1;
      pdSeen <= 1'b0;
    end
    else
    begin
      since <= next_since;
      low   <= next_low;
      bits  <= next_bits;
      fall  <= next_fall;
      sclkQ <= next_sclkQ;
      pdSeen <= next_pdSeen;
    end
  end

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!nrst);

  a_first_load: assert property ($fell(resultReadyN) |-> since >= START)
    else $error("ready fell before three periods");
  a_gap_before_load: assert property (!pdSeen |-> low <= LOWMAX)
    else $error("ready low past the gap");
  a_read_release: assert property ($fell(linkOut.serialDataIoOe) && bits == 5'd24 |-> resultReadyN)
    else $error("ready low after word read");
  a_read_length: assert property ($fell(linkOut.serialDataIoOe) |-> bits == 5'd24 || bits == 5'd8)
    else $error("read frame of wrong length");
  a_bit_launch: assert property ($rose(linkOut.serialDataIoOe)
    || linkOut.serialDataIoOe && $changed(linkOut.serialDataIoOut) |-> fall <= 5'd6)
    else $error("data launched away from sclk fall");
  a_standby_no_load: assert property (setupOut.power_down_bit && $past(setupOut.power_down_bit)
    |-> !$fell(resultReadyN))
    else $error("load during standby");
  a_standby_release: assert property (setupOut.power_down_bit && $rose(resultReadyN)
    |-> linkOut.serialDataIoOe)
    else $error("ready rose in standby without read");
  a_setup_write: assert property ($changed(setupOut) |-> !linkOut.serialDataIoOe
    && setupOut.zeroTop == 1'b0 && setupOut.zeroLow == 4'h0)
    else $error("bad setup update");
endmodule

bind adc_result_ready_standby_ctrl adc_ctrl_assertions #(.UPDATE_TICKS(UPDATE_TICKS)) chk (
  .clk(clk), .nrst(nrst), .linkIn(linkIn), .linkOut(linkOut),
  .resultReadyN(resultReadyN), .sampleData(sampleData), .setupOut(setupOut));
`default_nettype wire

// file: dv/adc_host_model.sv
// Purpose: Host side of the two-wire link.
// Assumes: Device launches on sclk fall; host samples on sclk rise.
// Notes:   sclk period 160 ns, stands high between frames; pin pulled up.
`timescale 1ns/1ns
`default_nettype none
module adc_host_model
  import adc_ctrl_pkg::*;
(
  // Clock
  input  wire logic                    clk,
  // Link
  input  wire adc_ctrl_pkg::link_out_t linkOut,
  output wire adc_ctrl_pkg::link_in_t  linkIn
);
  logic sclk    = 1'b1;
  logic hostOe  = 1'b0;
  logic hostBit = 1'b1;
  wire  pin;

  // Released pin goes to the pull-up level
  assign pin = linkOut.serialDataIoOe ? linkOut.serialDataIoOut : (hostOe ? hostBit : 1'b1);
  assign linkIn = {sclk, pin};

  task automatic half();
    repeat (20) @(posedge clk);
    #1;
  endtask

  task automatic frame(input logic [7:0] cmd, input logic [7:0] wdata, input int nRead, output logic [23:0] rdata);
    logic [15:0] out;
    out = {cmd, wdata};
    rdata = '0;
    hostOe = 1'b1;
    hostBit = 1'b0;
    half();
    sclk = 1'b0;
    for (int i = 0; i < ((cmd == 8'hBF) ? 16 : 8); i++)
    begin
      hostBit = out[15 - i];
      half();
      sclk = 1'b1;
      half();
      sclk = 1'b0;
    end
    if (nRead > 0)
    begin
      hostOe = 1'b0;
      for (int i = 0; i < nRead; i++)
      begin
        half();
        sclk = 1'b1;
        rdata = {rdata[22:0], pin};
        half();
        sclk = 1'b0;
      end
      // Device lets go a few clk after this fall; wait to avoid a fight
      repeat (8) @(posedge clk);
      #1;
    end
    hostOe = 1'b1;
    hostBit = 1'b0;
    half();
    sclk = 1'b1;
    half();
    hostBit = 1'b1;
    half();
    hostOe = 1'b0;
    // Idle gap so the next start is a separate event
    half();
  endtask
endmodule
`default_nettype wire

// file: dv/adc_result_ready_standby_ctrl_bench.sv
// Purpose: Self-checking bench for the result/standby control block.
// Assumes: Host reads only while ready is low.
// Notes:   Short update period keeps the run near 90k cycles.
`timescale 1ns/1ns
`default_nettype none
module adc_result_ready_standby_ctrl_bench;
  import adc_ctrl_pkg::*;
  localparam int unsigned TICKS  = 540;
  localparam int unsigned PERIOD = TICKS * 50;
  logic               clk = 1'b0;
  logic               nrst = 1'b0;
  logic signed [23:0] sampleData = 24'sh7FFFFF;
  link_in_t           linkIn;
  link_out_t          linkOut;
  logic               resultReadyN;
  setup_t             setupOut;
  logic [23:0]        rd;
  int                 n_mismatch = 0;
  int                 checked = 0;
  int                 cycles = 0;
  time                tRel;

  adc_result_ready_standby_ctrl #(.UPDATE_TICKS(TICKS)) DUT (.clk(clk), .nrst(nrst), .linkIn(linkIn),
    .linkOut(linkOut), .resultReadyN(resultReadyN), .sampleData(sampleData), .setupOut(setupOut));
  adc_host_model host (.clk(clk), .linkOut(linkOut), .linkIn(linkIn));

  initial
    forever #2 clk = ~clk;

  task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic test_done();
    $display("Counts: %0d checks, %0d mismatches", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask

  task automatic t_power_up();
    host.frame(8'h3F, 8'h00, 8, rd);
    check("setup", 24'(setupOut), 24'h000020);
    check("ready poll", rd, 24'h0000FF);
    check("ready pin", 24'(resultReadyN), 24'h000001);
    $display("t_power_up done");
  endtask

  task automatic t_first_load();
    longint clks;
    while (resultReadyN !== 1'b0)
    begin
      @(posedge clk);
      #1;
    end
    clks = ($time - tRel) / 4;
    check("load delay", 24'(clks >= 3 * PERIOD - 100 && clks <= 3 * PERIOD + 100), 24'h1);
    host.frame(8'h3F, 8'h00, 8, rd);
    check("ready poll", rd, 24'h000000);
    $display("t_first_load done");
  endtask

  task automatic t_standby_read();
    // Ignored bits written high on purpose
    host.frame(8'hBF, 8'hFF, 0, rd);
    sampleData = 24'sh000000;
    check("setup", 24'(setupOut), 24'h000070);
    check("ready kept", 24'(resultReadyN), 24'h0);
    host.frame(8'h7F, 8'h00, 24, rd);
    check("result word", rd, 24'hD2F000);
    check("ready after read", 24'(resultReadyN), 24'h1);
    $display("t_standby_read done");
  endtask

  task automatic t_standby_exit();
    host.frame(8'hBF, 8'h20, 0, rd);
    check("setup", 24'(setupOut), 24'h000020);
    repeat (PERIOD / 4) @(posedge clk);
    #1;
    check("ready held", 24'(resultReadyN), 24'h1);
    $display("t_standby_exit done");
  endtask

  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3 * PERIOD + PERIOD / 4 + 8000)
    begin
      n_mismatch++;
      test_done();
    end
  end

  initial
  begin
    repeat (5) @(posedge clk);
    #1;
    nrst = 1'b1;
    tRel = $time;
    repeat (3) @(posedge clk);
    #1;
    t_power_up();
    t_first_load();
    t_standby_read();
    t_standby_exit();
    test_done();
  end
endmodule
`default_nettype wire
